// ---- include/aofr_pkg.sv ----
// constants for the output feature register bank
package aofr_pkg;
    localparam int DATA_W = 14;
    localparam logic [7:0] ADDR_TEST = 8'h0d;
    localparam logic [7:0] ADDR_OFFSET = 8'h10;
    localparam logic [7:0] ADDR_FORMAT = 8'h14;
    localparam logic [7:0] ADDR_PHASE = 8'h16;
    localparam logic [7:0] ADDR_REF = 8'h18;
    localparam logic [7:0] ADDR_UPDATE = 8'hff;
    localparam logic [7:0] RST_TEST = 8'h00;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_FORMAT = 8'h00;
    localparam logic [7:0] RST_PHASE = 8'h00;
    localparam logic [7:0] RST_REF = 8'hc0;
    // field positions
    localparam int UPDATE_BIT = 0;
    localparam int LONG_RST_BIT = 5;
    localparam int SHORT_RST_BIT = 4;
    localparam int TEST_LSB = 0;
    localparam int TEST_MSB = 2;
    localparam int OFF_MSB = 5;
    localparam int DRV_LSB = 6;
    localparam int DISABLE_BIT = 4;
    localparam int INVERT_BIT = 2;
    localparam int FMT_LSB = 0;
    localparam int POL_BIT = 7;
    localparam int REF_LSB = 6;
    // test source codes
    localparam logic [2:0] TP_OFF = 3'h0;
    localparam logic [2:0] TP_MID = 3'h1;
    localparam logic [2:0] TP_PFS = 3'h2;
    localparam logic [2:0] TP_NFS = 3'h3;
    localparam logic [2:0] TP_CHECK = 3'h4;
    localparam logic [2:0] TP_LONG = 3'h5;
    localparam logic [2:0] TP_SHORT = 3'h6;
    localparam logic [2:0] TP_TOGGLE = 3'h7;
    // format codes
    localparam logic [1:0] FMT_BIN = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    // pattern words, offset binary
    localparam logic [13:0] WORD_MID = 14'h2000;
    localparam logic [13:0] WORD_PFS = 14'h3fff;
    localparam logic [13:0] WORD_NFS = 14'h0000;
    localparam logic [13:0] WORD_CHECK_A = 14'h2aaa;
    localparam logic [13:0] WORD_CHECK_B = 14'h1555;
    localparam logic [15:0] SAT_MAX = 16'h3fff;
    // sequence generators
    localparam int LONG_W = 23;
    localparam int LONG_TAP = 18;
    localparam logic [22:0] LONG_SEED = 23'h7fffff;
    localparam int SHORT_W = 9;
    localparam int SHORT_TAP = 5;
    localparam logic [8:0] SHORT_SEED = 9'h1ff;
endpackage

// ---- logic/aofr_prbs.sv ----
// linear feedback sequence generator with hold-in-reset
`timescale 1ns/100ps
`default_nettype none
module aofr_prbs #(
    parameter int WIDTH = 9,
    parameter int TAP = 5,
    parameter logic [WIDTH-1:0] SEED = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic hold,
    input wire logic step,
    // sequence state
    output logic [WIDTH-1:0] state
);
    logic feedback;

    assign feedback = state[WIDTH-1] ^ state[TAP-1];

    always_ff @(posedge clk)
    begin
        if (!rst_n || hold)
        begin
            state <= SEED;
        end
        else if (step)
        begin
            state <= {state[WIDTH-2:0], feedback};
        end
    end
endmodule
`default_nettype wire

// ---- logic/aofr_top.sv ----
// output feature registers and converter output data path
`timescale 1ns/100ps
`default_nettype none
module aofr_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port from serial decoder
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    // converter side
    input wire logic sample_clk,
    input wire logic [13:0] adc_data,
    input wire logic output_enable_pin_n,
    // output pins
    output logic [13:0] data_out,
    output logic data_out_oe,
    output logic data_output_clock,
    // analog settings
    output logic [1:0] output_driver_supply_sel,
    output logic [1:0] ref_voltage_sel
);
    // staged copies written by the host
    logic [7:0] test_stg_reg;
    logic [7:0] offset_stg_reg;
    logic [7:0] format_stg_reg;
    logic [7:0] phase_stg_reg;
    logic [7:0] ref_stg_reg;
    // active copies steering the logic
    logic [7:0] test_reg;
    logic [7:0] offset_reg;
    logic [7:0] format_reg;
    logic [7:0] phase_reg;
    logic [7:0] ref_reg;
    logic [7:0] rdata_next;
    logic update_req;

    // sampling of outside-domain inputs
    logic [1:0] sclk_sync_reg;
    logic sclk_prev_reg;
    logic [13:0] adc_sync1_reg;
    logic [13:0] adc_sync2_reg;
    logic [1:0] oe_sync_reg;
    logic sample_en;

    logic [aofr_pkg::LONG_W-1:0] long_state;
    logic [aofr_pkg::SHORT_W-1:0] short_state;
    logic phase_flip_reg;
    logic [15:0] sum;
    logic [13:0] corrected;
    logic [13:0] source;
    logic [13:0] formatted;
    logic [13:0] data_next;

    assign update_req = reg_wr && reg_addr == aofr_pkg::ADDR_UPDATE
                        && reg_wdata[aofr_pkg::UPDATE_BIT];

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            test_stg_reg <= aofr_pkg::RST_TEST;
            offset_stg_reg <= aofr_pkg::RST_OFFSET;
            format_stg_reg <= aofr_pkg::RST_FORMAT;
            phase_stg_reg <= aofr_pkg::RST_PHASE;
            ref_stg_reg <= aofr_pkg::RST_REF;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                aofr_pkg::ADDR_TEST: test_stg_reg <= reg_wdata;
                aofr_pkg::ADDR_OFFSET: offset_stg_reg <= reg_wdata;
                aofr_pkg::ADDR_FORMAT: format_stg_reg <= reg_wdata;
                aofr_pkg::ADDR_PHASE: phase_stg_reg <= reg_wdata;
                aofr_pkg::ADDR_REF: ref_stg_reg <= reg_wdata;
                default: ;
            endcase
        end
    end

    // staged values take effect only on the update bit
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            test_reg <= aofr_pkg::RST_TEST;
            offset_reg <= aofr_pkg::RST_OFFSET;
            format_reg <= aofr_pkg::RST_FORMAT;
            phase_reg <= aofr_pkg::RST_PHASE;
            ref_reg <= aofr_pkg::RST_REF;
        end
        else if (update_req)
        begin
            test_reg <= test_stg_reg;
            offset_reg <= offset_stg_reg;
            format_reg <= format_stg_reg;
            phase_reg <= phase_stg_reg;
            ref_reg <= ref_stg_reg;
        end
    end

    // reads show the staged copy; update bit self-clears so reads 0
    always_comb
    begin
        case (reg_addr)
            aofr_pkg::ADDR_TEST: rdata_next = test_stg_reg;
            aofr_pkg::ADDR_OFFSET: rdata_next = offset_stg_reg;
            aofr_pkg::ADDR_FORMAT: rdata_next = format_stg_reg;
            aofr_pkg::ADDR_PHASE: rdata_next = phase_stg_reg;
            aofr_pkg::ADDR_REF: rdata_next = ref_stg_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= rdata_next;
        end
    end

    // sample clock, data and pin cross in through two flops
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sclk_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
            adc_sync1_reg <= 14'h0000;
            adc_sync2_reg <= 14'h0000;
            oe_sync_reg <= 2'h0;
        end
        else
        begin
            sclk_sync_reg <= {sclk_sync_reg[0], sample_clk};
            sclk_prev_reg <= sclk_sync_reg[1];
            adc_sync1_reg <= adc_data;
            adc_sync2_reg <= adc_sync1_reg;
            oe_sync_reg <= {oe_sync_reg[0], output_enable_pin_n};
        end
    end

    assign sample_en = sclk_sync_reg[1] && !sclk_prev_reg;

    aofr_prbs #(
        .WIDTH(aofr_pkg::LONG_W),
        .TAP(aofr_pkg::LONG_TAP),
        .SEED(aofr_pkg::LONG_SEED)
    ) u_long_prbs_sequence (
        .clk(clk),
        .rst_n(rst_n),
        .hold(test_reg[aofr_pkg::LONG_RST_BIT]),
        .step(sample_en),
        .state(long_state)
    );

    aofr_prbs #(
        .WIDTH(aofr_pkg::SHORT_W),
        .TAP(aofr_pkg::SHORT_TAP),
        .SEED(aofr_pkg::SHORT_SEED)
    ) u_short_prbs_sequence (
        .clk(clk),
        .rst_n(rst_n),
        .hold(test_reg[aofr_pkg::SHORT_RST_BIT]),
        .step(sample_en),
        .state(short_state)
    );

    // checker and toggle patterns alternate per sample
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            phase_flip_reg <= 1'b0;
        end
        else if (sample_en)
        begin
            phase_flip_reg <= !phase_flip_reg;
        end
    end

    // offset with saturation, so corrections never wrap around
    assign sum = {2'b00, adc_sync2_reg}
                 + {{10{offset_reg[aofr_pkg::OFF_MSB]}}, offset_reg[aofr_pkg::OFF_MSB:0]};

    always_comb
    begin
        if (sum[15])
        begin
            corrected = aofr_pkg::WORD_NFS;
        end
        else if (sum > aofr_pkg::SAT_MAX)
        begin
            corrected = aofr_pkg::WORD_PFS;
        end
        else
        begin
            corrected = sum[13:0];
        end
    end

    // patterns replace corrected data, then pass formatting
    always_comb
    begin
        case (test_reg[aofr_pkg::TEST_MSB:aofr_pkg::TEST_LSB])
            aofr_pkg::TP_OFF: source = corrected;
            aofr_pkg::TP_MID: source = aofr_pkg::WORD_MID;
            aofr_pkg::TP_PFS: source = aofr_pkg::WORD_PFS;
            aofr_pkg::TP_NFS: source = aofr_pkg::WORD_NFS;
            aofr_pkg::TP_CHECK:
                source = phase_flip_reg ? aofr_pkg::WORD_CHECK_B
                                        : aofr_pkg::WORD_CHECK_A;
            aofr_pkg::TP_LONG: source = long_state[13:0];
            aofr_pkg::TP_SHORT: source = {5'h00, short_state};
            aofr_pkg::TP_TOGGLE: source = {14{phase_flip_reg}};
            default: source = corrected;
        endcase
    end

    always_comb
    begin
        case (format_reg[aofr_pkg::FMT_LSB+1:aofr_pkg::FMT_LSB])
            aofr_pkg::FMT_TWOS: formatted = {!source[13], source[12:0]};
            aofr_pkg::FMT_GRAY: formatted = source ^ {1'b0, source[13:1]};
            default: formatted = source;
        endcase
        data_next = format_reg[aofr_pkg::INVERT_BIT] ? ~formatted : formatted;
    end

    // outputs, each from a flop
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            data_out <= 14'h0000;
            data_out_oe <= 1'b0;
            data_output_clock <= 1'b0;
            output_driver_supply_sel <=
                aofr_pkg::RST_FORMAT[aofr_pkg::DRV_LSB+1:aofr_pkg::DRV_LSB];
            ref_voltage_sel <= aofr_pkg::RST_REF[aofr_pkg::REF_LSB+1:aofr_pkg::REF_LSB];
        end
        else
        begin
            if (sample_en)
            begin
                data_out <= data_next;
            end
            data_out_oe <= !format_reg[aofr_pkg::DISABLE_BIT] && oe_sync_reg[1];
            data_output_clock <= sclk_sync_reg[1] ^ phase_reg[aofr_pkg::POL_BIT];
            output_driver_supply_sel <= format_reg[aofr_pkg::DRV_LSB+1:aofr_pkg::DRV_LSB];
            ref_voltage_sel <= ref_reg[aofr_pkg::REF_LSB+1:aofr_pkg::REF_LSB];
        end
    end
endmodule
`default_nettype wire

// ---- tb/aofr_host_model.sv ----
// host model driving the register port of the feature bank
`timescale 1ns/100ps
`default_nettype none
module aofr_host_model (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
    end
    // one-cycle strobe; data flipped once released so stale bits never match
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ---- tb/aofr_top_assertions.sv ----
// concurrent checks on the feature bank ports
`timescale 1ns/100ps
`default_nettype none
module aofr_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic [7:0] reg_rdata,
    // pins
    input wire logic output_enable_pin_n,
    input wire logic [13:0] data_out,
    input wire logic data_out_oe,
    input wire logic data_output_clock,
    input wire logic [1:0] output_driver_supply_sel,
    input wire logic [1:0] ref_voltage_sel
);
    logic upd;
    logic [1:0] st_ref_reg;
    logic [1:0] st_drv_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    assign upd = reg_wr && reg_addr == aofr_pkg::ADDR_UPDATE && reg_wdata[0];
    // staged copies of the two analog fields
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_ref_reg <= 2'h3;
        else if (reg_wr && reg_addr == aofr_pkg::ADDR_REF)
            st_ref_reg <= reg_wdata[7:6];
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            st_drv_reg <= 2'h0;
        else if (reg_wr && reg_addr == aofr_pkg::ADDR_FORMAT)
            st_drv_reg <= reg_wdata[7:6];
    end
    rst_vals_a: assert property (
        $rose(rst_n) |-> !data_out_oe && ref_voltage_sel == 2'h3
        && output_driver_supply_sel == 2'h0 && reg_rdata == 8'h00) else $error("reset values");
    pin_off_a: assert property (
        !output_enable_pin_n [*4] |-> !data_out_oe) else $error("oe with pin low");
    oe_pin_a: assert property (
        data_out_oe |-> $past(output_enable_pin_n, 3)) else $error("oe without pin");
    data_edge_a: assert property (
        !$stable(data_out) |-> !$stable(data_output_clock)) else $error("data off edge");
    read_back_a: assert property (
        reg_wr && reg_addr == aofr_pkg::ADDR_REF ##1 reg_addr == aofr_pkg::ADDR_REF
        |=> reg_rdata[7:6] == $past(reg_wdata[7:6], 2)) else $error("staged readback");
    upd_read_a: assert property (
        reg_addr == aofr_pkg::ADDR_UPDATE |=> reg_rdata == 8'h00) else $error("update reads");
    sel_hold_a: assert property (
        !$stable({ref_voltage_sel, output_driver_supply_sel}) |-> $past(upd) || $past(upd, 2))
        else $error("active change without update");
    sel_apply_a: assert property (
        upd |-> ##[1:3] ref_voltage_sel == st_ref_reg && output_driver_supply_sel == st_drv_reg)
        else $error("update not applied");
endmodule
bind aofr_top aofr_checker i_aofr_checker (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .output_enable_pin_n(output_enable_pin_n), .data_out(data_out), .data_out_oe(data_out_oe),
    .data_output_clock(data_output_clock), .output_driver_supply_sel(output_driver_supply_sel),
    .ref_voltage_sel(ref_voltage_sel));
`default_nettype wire

// ---- tb/aofr_top_tb.sv ----
// self-checking bench for the output feature register bank
`timescale 1ns/100ps
`default_nettype none
module aofr_top_tb;
    logic clk, rst_n, sample_clk, pin_n, reg_wr, oe, dclk;
    logic [13:0] adc_data, data_out, w0, w1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [1:0] drv_sel, ref_sel;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    aofr_top i_aofr_top (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata), .sample_clk(sample_clk), .adc_data(adc_data),
        .output_enable_pin_n(pin_n), .data_out(data_out), .data_out_oe(oe),
        .data_output_clock(dclk), .output_driver_supply_sel(drv_sel), .ref_voltage_sel(ref_sel));
    aofr_host_model i_aofr_host_model (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rdata(reg_rdata));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // free-running sample clock, phase unrelated to clk
    initial
    begin
        sample_clk = 1'b0;
        #7.3;
        forever #32 sample_clk = ~sample_clk;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            summarize();
        end
    end
    task automatic summarize();
        $display("failures %0d n_tests %0d", failures, n_tests);
        if (failures == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cfg(input logic [7:0] a, input logic [7:0] d);
        i_aofr_host_model.wr(a, d);
        i_aofr_host_model.wr(aofr_pkg::ADDR_UPDATE, 8'h01);
        repeat (4) @(posedge clk);
    endtask
    // word of the next sample, read well after it settles
    task automatic smp(output logic [13:0] w);
        @(posedge sample_clk);
        repeat (8) @(posedge clk);
        w = data_out;
    endtask
    task automatic t_defaults();
        logic [7:0] ad[7] = '{8'h0d, 8'h10, 8'h14, 8'h16, 8'h18, 8'hff, 8'h20};
        logic [7:0] ex[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++)
        begin
            i_aofr_host_model.rd(ad[i], rv);
            chk("reset value", {8'h00, ex[i]}, {8'h00, rv});
        end
        i_aofr_host_model.wr(8'h20, 8'h55);
        i_aofr_host_model.rd(8'h20, rv);
        chk("unmapped", 16'h0000, {8'h00, rv});
        i_aofr_host_model.wr(aofr_pkg::ADDR_REF, 8'h40);
        i_aofr_host_model.rd(aofr_pkg::ADDR_REF, rv);
        chk("staged ref", 16'h0040, {8'h00, rv & 8'hc0});
        chk("ref before update", 16'h0003, {14'h0000, ref_sel});
    endtask
    task automatic t_data();
        logic [7:0] ov[3] = '{8'h1f, 8'h20, 8'h00};
        logic [13:0] oe_x[3] = '{14'h201f, 14'h1fe0, 14'h2000};
        logic [7:0] fv[4] = '{8'h01, 8'h02, 8'h04, 8'h00};
        logic [13:0] fe_x[4] = '{14'h0006, 14'h3005, 14'h1ff9, 14'h2006};
        adc_data <= 14'h2000;
        for (int i = 0; i < 3; i++)
        begin
            cfg(aofr_pkg::ADDR_OFFSET, ov[i]);
            smp(w0);
            chk("offset", {2'h0, oe_x[i]}, {2'h0, w0});
        end
        adc_data <= 14'h2005;
        cfg(aofr_pkg::ADDR_OFFSET, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            cfg(aofr_pkg::ADDR_FORMAT, fv[i]);
            smp(w0);
            chk("format", {2'h0, fe_x[i]}, {2'h0, w0});
        end
    endtask
    task automatic t_patterns();
        logic [13:0] px[3] = '{14'h2000, 14'h3fff, 14'h0000};
        for (int i = 1; i < 4; i++)
        begin
            cfg(aofr_pkg::ADDR_TEST, 8'(i));
            smp(w0);
            chk("fixed pattern", {2'h0, px[i - 1]}, {2'h0, w0});
        end
        cfg(aofr_pkg::ADDR_TEST, 8'h07);
        smp(w0);
        smp(w1);
        chk("toggle", 16'h3fff, {2'h0, w0 ^ w1});
        cfg(aofr_pkg::ADDR_TEST, 8'h04);
        smp(w0);
        smp(w1);
        chk("checker", 16'h0001, {15'h0000, (w0 ^ w1) == 14'h3fff && w0[0] != w0[1]});
        cfg(aofr_pkg::ADDR_TEST, 8'h25);
        smp(w0);
        smp(w1);
        chk("long held", 16'h3fff, {2'h0, w0 & w1});
        cfg(aofr_pkg::ADDR_TEST, 8'h05);
        // first sample after release may still show the seed
        smp(w0);
        smp(w0);
        chk("long runs", 16'h0001, {15'h0000, w0 !== 14'h3fff});
        cfg(aofr_pkg::ADDR_TEST, 8'h16);
        smp(w0);
        smp(w1);
        chk("short held", 16'h01ff, {2'h0, w0 | w1});
        cfg(aofr_pkg::ADDR_TEST, 8'h06);
        smp(w0);
        smp(w0);
        chk("short runs", 16'h0001, {15'h0000, w0 !== 14'h01ff});
        cfg(aofr_pkg::ADDR_TEST, 8'h00);
    endtask
    task automatic t_pins();
        chk("oe on", 16'h0001, {15'h0000, oe});
        cfg(aofr_pkg::ADDR_FORMAT, 8'h10);
        chk("oe disabled", 16'h0000, {15'h0000, oe});
        cfg(aofr_pkg::ADDR_FORMAT, 8'h80);
        chk("oe back", 16'h0001, {15'h0000, oe});
        chk("driver sel", 16'h0002, {14'h0000, drv_sel});
        pin_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk("oe pin low", 16'h0000, {15'h0000, oe});
        pin_n <= 1'b1;
        repeat (6) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            cfg(aofr_pkg::ADDR_REF, 8'(i << 6));
            chk("ref sel", 16'(i), {14'h0000, ref_sel});
        end
        for (int p = 0; p < 2; p++)
        begin
            cfg(aofr_pkg::ADDR_PHASE, 8'(p << 7));
            @(posedge sample_clk);
            repeat (6) @(posedge clk);
            chk("clock high", 16'(p == 0), {15'h0000, dclk});
            @(negedge sample_clk);
            repeat (6) @(posedge clk);
            chk("clock low", 16'(p), {15'h0000, dclk});
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        adc_data = 14'h0000;
        pin_n = 1'b1;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_defaults();
        t_data();
        t_patterns();
        t_pins();
        summarize();
    end
endmodule
`default_nettype wire
